// *** common/trig_seq_pkg.sv ***
// Shared constants, register map and types of the trigger sequencer and error queue
package trig_seq_pkg;
	localparam int unsigned CLK_FREQ_HZ = 20_000_000;
	localparam int unsigned DELAY_TICK_US = 1;
	localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * DELAY_TICK_US;
	localparam int unsigned AC_AUTO_DELAY_US = 500_000;
	localparam int unsigned QUEUE_DEPTH = 30;

	localparam logic [23:0] COUNT_MIN = 24'h000001;
	localparam logic [23:0] COUNT_MAX = 24'hFFFFFF;
	localparam logic [23:0] DELAY_MIN_DC = 24'h000000;
	localparam logic [23:0] DELAY_MAX = 24'hFFFFFF;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_AUTO = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_ERROR = 8'h18;
	localparam logic [7:0] OFS_DONE = 8'h1C;
	localparam logic [7:0] OFS_COUNT_MIN = 8'h20;
	localparam logic [7:0] OFS_COUNT_MAX = 8'h24;
	localparam logic [7:0] OFS_DELAY_MIN = 8'h28;
	localparam logic [7:0] OFS_DELAY_MAX = 8'h2C;

	localparam int CTRL_ARM = 0;
	localparam int CTRL_IMM = 1;
	localparam int CTRL_BUS_TRIG = 2;
	localparam int CTRL_CLEAR = 3;
	localparam int CTRL_FUNC_CMD = 4;
	localparam int CTRL_ABORT = 5;
	localparam int CTRL_FETCH = 6;
	localparam int AUTO_BIT = 0;
	localparam int SEL_LSB = 24;
	localparam int SEL_MSB = 25;
	localparam logic [1:0] SEL_MIN = 2'h1;
	localparam logic [1:0] SEL_MAX = 2'h2;

	typedef enum logic [1:0] {FUNC_DCV = 2'h0, FUNC_ACV = 2'h1, FUNC_RES = 2'h2} func_t;
	typedef enum logic [1:0] {SRC_IMM = 2'h0, SRC_BUS = 2'h1, SRC_HOLD = 2'h2, SRC_EXT = 2'h3} src_t;
	typedef struct packed {
		logic scan;
		src_t source;
		func_t func;
	} config_t;
	localparam int CFG_W = $bits(config_t);
	localparam config_t CFG_RESET = '{scan: 1'b0, source: SRC_IMM, func: FUNC_DCV};

	typedef struct packed {
		logic [15:0] code;
		logic [7:0] msg;
	} err_entry_t;
	localparam logic [15:0] ERR_CODE_NONE = 16'h0000;
	localparam logic [15:0] ERR_CODE_OVERFLOW = 16'hFEA2;
	localparam logic [7:0] MSG_NONE = 8'h00;
	localparam logic [7:0] MSG_OVERFLOW = 8'h01;
	localparam logic [7:0] MSG_OUT_OF_MEM = 8'h02;
	localparam logic [7:0] MSG_TRIG_IGNORED = 8'h03;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DELAY = 2'b11,
		ST_MEAS = 2'b10
	} seq_state_t;
endpackage : trig_seq_pkg

// *** hdl/err_queue.sv ***
// First-in first-out error queue with overflow marker
`timescale 1ns/1ps
`default_nettype none
module err_queue (
	input wire logic clk,
	input wire logic srst,
	input wire logic push,
	input wire trig_seq_pkg::err_entry_t push_entry,
	input wire logic pop,
	input wire logic clear,
	output trig_seq_pkg::err_entry_t head,
	output logic [4:0] fill,
	output logic empty
);
	localparam logic [4:0] LAST = 5'(trig_seq_pkg::QUEUE_DEPTH - 1);
	localparam logic [4:0] FULL = 5'(trig_seq_pkg::QUEUE_DEPTH);
	localparam trig_seq_pkg::err_entry_t OVF_ENTRY = '{code: trig_seq_pkg::ERR_CODE_OVERFLOW,
		msg: trig_seq_pkg::MSG_OVERFLOW};

	trig_seq_pkg::err_entry_t slots [trig_seq_pkg::QUEUE_DEPTH];
	logic [4:0] rd_ptr, wr_ptr, wr_last, wr_addr;
	logic overflowed, full, do_pop, accept, mark;

	function automatic logic [4:0] wrap_inc(input logic [4:0] p);
		return (p == LAST) ? 5'h00 : p + 5'h01;
	endfunction : wrap_inc

	assign empty = (fill == 5'h00);
	assign full = (fill == FULL);
	assign do_pop = pop && !empty && !clear;
	// A pop in the same cycle frees the slot that a push into a full queue needs
	assign accept = push && (clear || !full || do_pop);
	assign mark = push && full && !do_pop && !overflowed && !clear;
	assign wr_last = (wr_ptr == 5'h00) ? LAST : wr_ptr - 5'h01;
	assign wr_addr = clear ? 5'h00 : (mark ? wr_last : wr_ptr);
	assign head = slots[rd_ptr];

	always_ff @(posedge clk) begin
		if (accept || mark) begin
			slots[wr_addr] <= mark ? OVF_ENTRY : push_entry;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_ptr <= 5'h00;
			wr_ptr <= 5'h00;
			fill <= 5'h00;
		end else if (clear) begin
			// An error arriving with the clear survives it
			rd_ptr <= 5'h00;
			wr_ptr <= push ? 5'h01 : 5'h00;
			fill <= push ? 5'h01 : 5'h00;
		end else begin
			if (do_pop) begin
				rd_ptr <= wrap_inc(rd_ptr);
			end
			if (accept) begin
				wr_ptr <= wrap_inc(wr_ptr);
			end
			fill <= fill + 5'(accept) - 5'(do_pop);
		end
	end

	always_ff @(posedge clk) begin
		if (srst || clear || do_pop) begin
			overflowed <= 1'b0;
		end else if (mark) begin
			overflowed <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_fill_bound: assert property (fill <= FULL)
		else $error("error queue holds more than its capacity");
	a_overflow_code: assert property (mark |=> slots[$past(wr_last)].code ==
		trig_seq_pkg::ERR_CODE_OVERFLOW && fill == FULL)
		else $error("overflow did not mark the newest slot");
	a_clear_empties: assert property (clear && !push |=> empty)
		else $error("clear left entries in the queue");
	a_drop_after_mark: assert property (overflowed && push && !pop && !clear |=>
		fill == FULL && $stable(wr_ptr))
		else $error("error accepted while queue was overflowed");
endmodule : err_queue
`default_nettype wire

// *** hdl/trigger_sequencer.sv ***
// Trigger sequencer with APB register file and error reporting
//
// Notes on behaviour
// - Every detected error enters the error queue
// - Queue read returns and removes oldest entry
// - Empty queue read returns code zero, no-error
// - Clear-status command empties the queue at once; here an error pushed in the same cycle is kept
// - Thirty entries; overflow marks newest, then drops
// - Trigger count ranges from one to 16777215
// - After programmed triggers, return to idle
// - Maximum count setting logs out-of-memory error
// - Scanning: count means channel-list passes
// - Function commands and reset set count one
// - Trigger delay holds 0 to 16.777215 seconds
// - Delay min depends on function; max fixed
// - Delay applied once per trigger, before start
// - Writing a delay turns automatic delay off
// - Automatic delay: zero DC/res, half second AC
// - Automatic-delay query reads one or zero
// - Immediate trigger only when waiting, bus/hold
// - Immediate trigger leaves trigger source unchanged
// - Immediate-trigger readings held until fetch
// - Count query returns current, min or max
// - Delay query returns current, min or max
// - External source fires on falling input edge
// - Hold source accepts only immediate trigger
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer #(
	parameter int unsigned AC_AUTO_DELAY_US = trig_seq_pkg::AC_AUTO_DELAY_US,
	parameter logic [15:0] OUT_OF_MEM_CODE = 16'hFF00,
	parameter logic [15:0] TRIG_IGNORED_CODE = 16'hFF01
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_TRIG,
	input wire logic MEAS_DONE,
	input wire logic ENG_ERR_PUSH,
	input wire trig_seq_pkg::err_entry_t ENG_ERR_ENTRY,
	output logic MEAS_START,
	output logic SCAN_MODE,
	output logic [1:0] FUNC_SEL,
	output logic ARMED,
	output logic ROUTE_TO_MEMORY,
	output logic FETCH_REQ
);
	localparam logic [4:0] TICK_LAST = 5'(trig_seq_pkg::TICK_CYCLES - 1);
	localparam logic [23:0] AC_DELAY = 24'(AC_AUTO_DELAY_US);
	localparam logic [31:0] NONE_WORD = {8'h00, trig_seq_pkg::ERR_CODE_NONE, trig_seq_pkg::MSG_NONE};

	trig_seq_pkg::seq_state_t st;
	trig_seq_pkg::config_t cfg;
	logic [23:0] trig_count, trig_delay, done_cnt, dcnt;
	logic [23:0] count_val, delay_val, delay_min, start_delay;
	logic auto_mode, tick;
	logic [4:0] tick_div;
	logic ext_s1, ext_s2, ext_prev, ext_fall;
	logic setup, acc, wr_acc, pop_armed, rd_err_acc, rd_mapped;
	logic ctrl_wr, count_wr, delay_wr, auto_wr, cfg_wr;
	logic arm_cmd, imm_cmd, bus_cmd, clear_cmd, func_cmd, abort_cmd, fetch_cmd;
	logic imm_ok, trig_fire, ign_evt, oom_evt, int_pend, q_push, q_empty;
	logic [31:0] rd_word;
	logic [4:0] q_fill;
	trig_seq_pkg::err_entry_t int_entry, q_entry, q_head;

	function automatic logic soft_source(input trig_seq_pkg::src_t s);
		return (s == trig_seq_pkg::SRC_BUS) || (s == trig_seq_pkg::SRC_HOLD);
	endfunction : soft_source

	function automatic logic [23:0] pick_value(input logic [1:0] sel, input logic [23:0] v,
		input logic [23:0] lo, input logic [23:0] hi);
		return (sel == trig_seq_pkg::SEL_MIN) ? lo : ((sel == trig_seq_pkg::SEL_MAX) ? hi : v);
	endfunction : pick_value

	// APB: no wait state; read data and error are captured at setup, so they come from flops
	assign setup = PSEL && !PENABLE;
	assign acc = PSEL && PENABLE && PREADY;
	assign wr_acc = acc && PWRITE && !PSLVERR;
	assign ctrl_wr = wr_acc && (PADDR == trig_seq_pkg::OFS_CTRL);
	assign count_wr = wr_acc && (PADDR == trig_seq_pkg::OFS_COUNT);
	assign delay_wr = wr_acc && (PADDR == trig_seq_pkg::OFS_DELAY);
	assign auto_wr = wr_acc && (PADDR == trig_seq_pkg::OFS_AUTO);
	assign cfg_wr = wr_acc && (PADDR == trig_seq_pkg::OFS_CONFIG);
	assign arm_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_ARM];
	assign imm_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_IMM];
	assign bus_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_BUS_TRIG];
	assign clear_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_CLEAR];
	assign func_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_FUNC_CMD];
	assign abort_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_ABORT];
	assign fetch_cmd = ctrl_wr && PWDATA[trig_seq_pkg::CTRL_FETCH];
	assign rd_err_acc = acc && !PWRITE && pop_armed;

	assign delay_min = (cfg.func == trig_seq_pkg::FUNC_ACV) ? AC_DELAY : trig_seq_pkg::DELAY_MIN_DC;
	assign count_val = pick_value(PWDATA[trig_seq_pkg::SEL_MSB:trig_seq_pkg::SEL_LSB],
		PWDATA[23:0], trig_seq_pkg::COUNT_MIN, trig_seq_pkg::COUNT_MAX);
	assign delay_val = pick_value(PWDATA[trig_seq_pkg::SEL_MSB:trig_seq_pkg::SEL_LSB],
		PWDATA[23:0], delay_min, trig_seq_pkg::DELAY_MAX);
	assign start_delay = auto_mode ? delay_min : trig_delay;

	assign ext_fall = ext_prev && !ext_s2;
	assign imm_ok = (st == trig_seq_pkg::ST_WAIT) && soft_source(cfg.source);
	// Hold and external sources never see the bus trigger; hold sees only the immediate one
	assign trig_fire = (st == trig_seq_pkg::ST_WAIT) && !abort_cmd && (
		(cfg.source == trig_seq_pkg::SRC_IMM) ||
		(cfg.source == trig_seq_pkg::SRC_EXT && ext_fall) ||
		(cfg.source == trig_seq_pkg::SRC_BUS && bus_cmd) ||
		(imm_cmd && imm_ok));
	assign ign_evt = (imm_cmd && !imm_ok) ||
		(bus_cmd && !(st == trig_seq_pkg::ST_WAIT && cfg.source == trig_seq_pkg::SRC_BUS));
	assign oom_evt = count_wr && (count_val == trig_seq_pkg::COUNT_MAX);
	assign tick = (tick_div == TICK_LAST);

	// The engine has the queue port first; an internal error waits until the engine push ends
	assign q_push = ENG_ERR_PUSH || int_pend;
	assign q_entry = ENG_ERR_PUSH ? ENG_ERR_ENTRY : int_entry;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_prev <= 1'b1;
		end else begin
			ext_s1 <= EXT_TRIG;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST || trig_fire || tick) begin
			tick_div <= 5'h00;
		end else begin
			tick_div <= tick_div + 5'h01;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			st <= trig_seq_pkg::ST_IDLE;
			done_cnt <= 24'h000000;
			dcnt <= 24'h000000;
		end else if (abort_cmd) begin
			st <= trig_seq_pkg::ST_IDLE;
		end else begin
			case (st)
				trig_seq_pkg::ST_IDLE: begin
					if (arm_cmd) begin
						st <= trig_seq_pkg::ST_WAIT;
						done_cnt <= 24'h000000;
					end
				end
				trig_seq_pkg::ST_WAIT: begin
					if (trig_fire) begin
						st <= trig_seq_pkg::ST_DELAY;
						dcnt <= start_delay;
					end
				end
				trig_seq_pkg::ST_DELAY: begin
					if (dcnt == 24'h000000) begin
						st <= trig_seq_pkg::ST_MEAS;
					end else if (tick) begin
						dcnt <= dcnt - 24'h000001;
					end
				end
				trig_seq_pkg::ST_MEAS: begin
					// One done per burst, or per full channel-list pass when scanning
					if (MEAS_DONE) begin
						done_cnt <= done_cnt + 24'h000001;
						// Compare with >= so a count lowered mid-run still ends the run
						st <= (done_cnt + 24'h000001 >= trig_count) ?
							trig_seq_pkg::ST_IDLE : trig_seq_pkg::ST_WAIT;
					end
				end
				default: st <= trig_seq_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			MEAS_START <= 1'b0;
			ARMED <= 1'b0;
		end else begin
			MEAS_START <= (st == trig_seq_pkg::ST_DELAY) && (dcnt == 24'h000000) && !abort_cmd;
			ARMED <= (st == trig_seq_pkg::ST_WAIT);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST || func_cmd) begin
			trig_count <= trig_seq_pkg::COUNT_MIN;
		end else if (count_wr && count_val != 24'h000000) begin
			trig_count <= count_val;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			trig_delay <= trig_seq_pkg::DELAY_MIN_DC;
			auto_mode <= 1'b1;
		end else if (delay_wr) begin
			trig_delay <= delay_val;
			auto_mode <= 1'b0;
		end else if (auto_wr) begin
			auto_mode <= PWDATA[trig_seq_pkg::AUTO_BIT];
		end
	end

	// The immediate trigger never touches the source field
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cfg <= trig_seq_pkg::CFG_RESET;
		end else if (func_cmd) begin
			cfg.source <= trig_seq_pkg::SRC_IMM;
		end else if (cfg_wr) begin
			cfg <= trig_seq_pkg::config_t'(PWDATA[trig_seq_pkg::CFG_W-1:0]);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			SCAN_MODE <= 1'b0;
			FUNC_SEL <= 2'h0;
			FETCH_REQ <= 1'b0;
		end else begin
			SCAN_MODE <= cfg.scan;
			FUNC_SEL <= cfg.func;
			FETCH_REQ <= fetch_cmd;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ROUTE_TO_MEMORY <= 1'b0;
		end else if (imm_cmd && imm_ok) begin
			ROUTE_TO_MEMORY <= 1'b1;
		end else if (fetch_cmd) begin
			ROUTE_TO_MEMORY <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			int_pend <= 1'b0;
			int_entry <= '{code: trig_seq_pkg::ERR_CODE_NONE, msg: trig_seq_pkg::MSG_NONE};
		end else if (oom_evt) begin
			int_pend <= 1'b1;
			int_entry <= '{code: OUT_OF_MEM_CODE, msg: trig_seq_pkg::MSG_OUT_OF_MEM};
		end else if (ign_evt) begin
			int_pend <= 1'b1;
			int_entry <= '{code: TRIG_IGNORED_CODE, msg: trig_seq_pkg::MSG_TRIG_IGNORED};
		end else if (!ENG_ERR_PUSH) begin
			int_pend <= 1'b0;
		end
	end

	always_comb begin
		rd_mapped = 1'b1;
		case (PADDR)
			trig_seq_pkg::OFS_CTRL: rd_word = 32'h00000000;
			trig_seq_pkg::OFS_COUNT: rd_word = {8'h00, trig_count};
			trig_seq_pkg::OFS_DELAY: rd_word = {8'h00, start_delay};
			trig_seq_pkg::OFS_AUTO: rd_word = {31'h00000000, auto_mode};
			trig_seq_pkg::OFS_CONFIG: rd_word = {27'h0000000, cfg};
			trig_seq_pkg::OFS_STATUS: rd_word = {19'h00000, q_fill, 3'h0, ROUTE_TO_MEMORY, 2'h0, st};
			trig_seq_pkg::OFS_ERROR: rd_word = q_empty ? NONE_WORD : {8'h00, q_head};
			trig_seq_pkg::OFS_DONE: rd_word = {8'h00, done_cnt};
			trig_seq_pkg::OFS_COUNT_MIN: rd_word = {8'h00, trig_seq_pkg::COUNT_MIN};
			trig_seq_pkg::OFS_COUNT_MAX: rd_word = {8'h00, trig_seq_pkg::COUNT_MAX};
			trig_seq_pkg::OFS_DELAY_MIN: rd_word = {8'h00, delay_min};
			trig_seq_pkg::OFS_DELAY_MAX: rd_word = {8'h00, trig_seq_pkg::DELAY_MAX};
			default: begin
				rd_word = 32'h00000000;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Pop is armed at setup so an error landing mid-transfer is never removed unread
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
			pop_armed <= 1'b0;
		end else if (setup) begin
			PREADY <= 1'b1;
			PRDATA <= PWRITE ? 32'h00000000 : rd_word;
			PSLVERR <= !rd_mapped;
			pop_armed <= !PWRITE && (PADDR == trig_seq_pkg::OFS_ERROR) && !q_empty;
		end else if (acc) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			pop_armed <= 1'b0;
		end
	end

	err_queue u_err_queue (
		.clk(REF_CLK),
		.srst(SRST),
		.push(q_push),
		.push_entry(q_entry),
		.pop(rd_err_acc),
		.clear(clear_cmd),
		.head(q_head),
		.fill(q_fill),
		.empty(q_empty)
	);

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	sequence s_err_setup;
		setup && !PWRITE && (PADDR == trig_seq_pkg::OFS_ERROR);
	endsequence
	sequence s_err_done;
		acc && !PWRITE && (PADDR == trig_seq_pkg::OFS_ERROR);
	endsequence

	a_err_read_head: assert property (s_err_setup ##0 !q_empty |=> PRDATA[23:0] == $past(q_head))
		else $error("error read did not return the oldest entry");
	a_err_pop_one: assert property (s_err_setup ##0 !q_empty ##1 s_err_done ##0
		(!clear_cmd && !q_push) |=> q_fill == $past(q_fill) - 5'h01)
		else $error("error read did not remove one entry");
	a_empty_read_none: assert property (s_err_setup ##0 q_empty |=> PRDATA == NONE_WORD)
		else $error("empty queue read did not return no-error");
	a_oom_logged: assert property (oom_evt |-> ##[1:4] (q_push && !ENG_ERR_PUSH &&
		q_entry.code == OUT_OF_MEM_CODE))
		else $error("maximum count did not log out-of-memory");
	a_count_done_idle: assert property (st == trig_seq_pkg::ST_MEAS && MEAS_DONE && !abort_cmd &&
		done_cnt + 24'h000001 >= trig_count |=> st == trig_seq_pkg::ST_IDLE ##1 !ARMED)
		else $error("sequencer did not return to idle after the count");
	a_func_count_one: assert property (func_cmd |=> trig_count == trig_seq_pkg::COUNT_MIN)
		else $error("function command did not reset the count");
	a_delay_auto_off: assert property (delay_wr |=> !auto_mode && trig_delay == $past(delay_val))
		else $error("delay write did not clear automatic mode");
	a_auto_ac_delay: assert property (trig_fire && auto_mode &&
		cfg.func == trig_seq_pkg::FUNC_ACV |=> dcnt == AC_DELAY)
		else $error("automatic AC delay not loaded");
	a_start_after_delay: assert property (MEAS_START |-> st == trig_seq_pkg::ST_MEAS &&
		$past(st) == trig_seq_pkg::ST_DELAY && $past(dcnt) == 24'h000000)
		else $error("measurement started without its delay");
	a_delay_tick: assert property (st == trig_seq_pkg::ST_DELAY && dcnt != 24'h000000 &&
		tick && !abort_cmd |=> dcnt == $past(dcnt) - 24'h000001)
		else $error("delay counter missed a microsecond tick");
	a_ext_fall_fires: assert property (st == trig_seq_pkg::ST_WAIT && ext_fall && !abort_cmd &&
		cfg.source == trig_seq_pkg::SRC_EXT |=> st == trig_seq_pkg::ST_DELAY)
		else $error("external falling edge did not trigger");
	a_hold_blocks: assert property (st == trig_seq_pkg::ST_WAIT && !ctrl_wr &&
		cfg.source == trig_seq_pkg::SRC_HOLD |=> st == trig_seq_pkg::ST_WAIT)
		else $error("hold source accepted a trigger");
	a_imm_keeps_src: assert property (imm_cmd && imm_ok && !cfg_wr |=> $stable(cfg.source))
		else $error("immediate trigger changed the source");
endmodule : trigger_sequencer
`default_nettype wire

// *** dv/meas_engine_model.sv ***
// Measurement engine stand-in that answers every start pulse with one done pulse
`timescale 1ns/1ps
`default_nettype none
module meas_engine_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [3:0] lat,
	output logic done = 1'b0
);
	// One done per burst, or per channel-list pass when scanning; latency comes from the bench
	always begin
		@(posedge clk);
		if (start === 1'b1 && srst === 1'b0) begin
			repeat (lat) @(posedge clk);
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
		end
	end
endmodule : meas_engine_model
`default_nettype wire

// *** dv/trigger_sequencer_tb.sv ***
// Self-checking bench: registers, trigger runs and the error queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module trigger_sequencer_tb;
	localparam logic [15:0] OOM = 16'hFF00;
	localparam logic [15:0] IGN = 16'hFF01;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic ext_trig = 1'b1;
	logic err_push = 1'b0;
	trig_seq_pkg::err_entry_t err_entry = '0;
	logic [3:0] lat = 4'h2;
	logic [31:0] prdata, rdata, v;
	logic [1:0] func_sel;
	logic pready, pslverr, slverr, meas_done, meas_start, scan_mode, armed, route, fetch_req;
	int error_cnt = 0;
	int comparisons = 0;
	int starts = 0;
	int fetches = 0;
	int seed = 32'h2FA0;
	int s0, d, k;
	time t0, t_start;
	logic [7:0] ra [6] = '{trig_seq_pkg::OFS_COUNT, trig_seq_pkg::OFS_AUTO,
		trig_seq_pkg::OFS_DELAY, trig_seq_pkg::OFS_ERROR, trig_seq_pkg::OFS_STATUS,
		trig_seq_pkg::OFS_COUNT_MAX};
	logic [31:0] re [6] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'hFFFFFF};

	trigger_sequencer #(.AC_AUTO_DELAY_US(5), .OUT_OF_MEM_CODE(OOM), .TRIG_IGNORED_CODE(IGN)) uut (
		.REF_CLK(ref_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_TRIG(ext_trig), .MEAS_DONE(meas_done), .ENG_ERR_PUSH(err_push),
		.ENG_ERR_ENTRY(err_entry), .MEAS_START(meas_start), .SCAN_MODE(scan_mode),
		.FUNC_SEL(func_sel), .ARMED(armed), .ROUTE_TO_MEMORY(route), .FETCH_REQ(fetch_req));
	meas_engine_model engine (.clk(ref_clk), .srst(srst), .start(meas_start), .lat(lat),
		.done(meas_done));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (meas_start === 1'b1) begin
			starts <= starts + 1;
			t_start <= $time;
		end
		// Counted here because the pulse is gone before the write task returns
		if (fetch_req === 1'b1) begin
			fetches <= fetches + 1;
		end
	end

	task automatic end_sim();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Called right after a rising edge; holds the request until PREADY is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			end_sim();
		end else begin
			rdata = prdata;
			slverr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rdata)
	endtask : rd
	task automatic wait_idle();
		k = 0;
		do begin apb(1'b0, trig_seq_pkg::OFS_STATUS, 32'h0); k++; end
		while (rdata[1:0] !== 2'h0 && k < 100);
		if (k >= 100) begin error_cnt++; end_sim(); end
	endtask : wait_idle
	task automatic cfg(input logic [1:0] f, input logic [1:0] s, input logic sc);
		apb(1'b1, trig_seq_pkg::OFS_CONFIG, {27'h0, sc, s, f});
	endtask : cfg

	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		foreach (ra[i]) rd(ra[i], re[i], "reset value");
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped slverr", 1'b1, slverr)
		$display("test registers done");
		v = {16'h0, 16'($random(seed))} + 32'h1;
		apb(1'b1, trig_seq_pkg::OFS_COUNT, v);
		rd(trig_seq_pkg::OFS_COUNT, v, "count");
		apb(1'b1, trig_seq_pkg::OFS_COUNT, 32'h0200_0000);
		rd(trig_seq_pkg::OFS_COUNT, 32'hFFFFFF, "count max");
		rd(trig_seq_pkg::OFS_ERROR, {8'h0, OOM, trig_seq_pkg::MSG_OUT_OF_MEM}, "oom");
		rd(trig_seq_pkg::OFS_ERROR, 32'h0, "empty queue");
		cfg(2'h0, trig_seq_pkg::SRC_BUS, 1'b0);
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h10);
		rd(trig_seq_pkg::OFS_COUNT, 32'h1, "count after func");
		rd(trig_seq_pkg::OFS_CONFIG, 32'h0, "source after func");
		d = 1 + ($random(seed) & 3);
		apb(1'b1, trig_seq_pkg::OFS_DELAY, 32'(d));
		rd(trig_seq_pkg::OFS_AUTO, 32'h0, "auto off");
		rd(trig_seq_pkg::OFS_DELAY, 32'(d), "delay");
		cfg(trig_seq_pkg::FUNC_ACV, trig_seq_pkg::SRC_IMM, 1'b0);
		rd(trig_seq_pkg::OFS_DELAY_MIN, 32'h5, "ac min");
		`CHK("func sel", 2'h1, func_sel)
		apb(1'b1, trig_seq_pkg::OFS_AUTO, 32'h1);
		rd(trig_seq_pkg::OFS_DELAY, 32'h5, "ac auto");
		s0 = starts;
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		wait_idle();
		`CHK("ac auto run", s0 + 1, starts)
		cfg(trig_seq_pkg::FUNC_DCV, trig_seq_pkg::SRC_BUS, 1'b0);
		apb(1'b1, trig_seq_pkg::OFS_DELAY, 32'(d));
		$display("test settings done");
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		s0 = starts;
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h4);
		t0 = $time;
		wait_idle();
		`CHK("one start", s0 + 1, starts)
		`CHK("delay", 1'b1, (t_start - t0) / 50 inside {[d*20-1 : d*20+5]})
		apb(1'b1, trig_seq_pkg::OFS_DELAY, 32'h0);
		cfg(trig_seq_pkg::FUNC_DCV, trig_seq_pkg::SRC_IMM, 1'b1);
		d = 2 + ($random(seed) & 3);
		lat <= 4'($random(seed));
		apb(1'b1, trig_seq_pkg::OFS_COUNT, 32'(d));
		s0 = starts;
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		wait_idle();
		`CHK("scan passes", s0 + d, starts)
		`CHK("scan mode", 1'b1, scan_mode)
		$display("test runs done");
		cfg(trig_seq_pkg::FUNC_DCV, trig_seq_pkg::SRC_HOLD, 1'b0);
		apb(1'b1, trig_seq_pkg::OFS_COUNT, 32'h1);
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		// The armed flag trails the state by one cycle
		@(posedge ref_clk);
		`CHK("armed", 1'b1, armed)
		s0 = starts;
		repeat (31) apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h4);
		`CHK("hold ignores bus", s0, starts)
		rd(trig_seq_pkg::OFS_STATUS, 32'h1E01, "queue full");
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h2);
		wait_idle();
		`CHK("immediate", s0 + 1, starts)
		`CHK("route", 1'b1, route)
		rd(trig_seq_pkg::OFS_CONFIG, 32'h8, "source kept");
		for (int i = 0; i < 30; i++) begin
			v = (i < 29) ? {8'h0, IGN, trig_seq_pkg::MSG_TRIG_IGNORED} :
				{8'h0, trig_seq_pkg::ERR_CODE_OVERFLOW, trig_seq_pkg::MSG_OVERFLOW};
			rd(trig_seq_pkg::OFS_ERROR, v, "pop");
		end
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h40);
		`CHK("fetch clears route", 1'b0, route)
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h2);
		`CHK("fetch pulse", 1, fetches)
		err_entry <= {16'($random(seed)), 8'($random(seed))};
		err_push <= 1'b1;
		@(posedge ref_clk);
		err_push <= 1'b0;
		@(posedge ref_clk);
		rd(trig_seq_pkg::OFS_ERROR, {8'h0, IGN, trig_seq_pkg::MSG_TRIG_IGNORED}, "refused");
		rd(trig_seq_pkg::OFS_ERROR, {8'h0, err_entry}, "engine error");
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h2);
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h8);
		rd(trig_seq_pkg::OFS_STATUS, 32'h0, "cleared");
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h20);
		rd(trig_seq_pkg::OFS_STATUS, 32'h0, "abort idles");
		$display("test queue done");
		cfg(trig_seq_pkg::FUNC_DCV, trig_seq_pkg::SRC_EXT, 1'b0);
		apb(1'b1, trig_seq_pkg::OFS_CTRL, 32'h1);
		s0 = starts;
		ext_trig <= 1'b0;
		wait_idle();
		ext_trig <= 1'b1;
		`CHK("external edge", s0 + 1, starts)
		$display("test external done");
		end_sim();
	end
	initial begin
		#2000000;
		error_cnt++;
		end_sim();
	end
endmodule : trigger_sequencer_tb
`default_nettype wire
